// ===== design/em_sup_pkg.sv
package em_sup_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SEC_MS = 1000;
  localparam int unsigned DECLARE_MS = 2500; // 2,5 s nominal persistency
  localparam int unsigned CLEAR_MS = 10000; // 10 s nominal absence
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SEC_CYCLES = SEC_MS * CYC_PER_MS;
  localparam int unsigned DECLARE_CYCLES = DECLARE_MS * CYC_PER_MS;
  localparam int unsigned CLEAR_CYCLES = CLEAR_MS * CYC_PER_MS;
  // local clock periods, in seconds of day
  localparam logic [16:0] DAY_SECONDS = 17'h15180; // 86400
  localparam logic [16:0] QUARTER_SECONDS = 17'h00384; // 900
  // fault cause indices
  localparam int NUM_CAUSES = 14;
  localparam int PDH_FIRST = 0;
  localparam int PDH_LAST = 6;
  localparam int MPEG_FIRST = 7;
  localparam int MPEG_LAST = 12;
  localparam int HW_FAIL_IDX = 13;
  // register offsets
  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] PATH_ID_OFS = 6'h04;
  localparam logic [5:0] FAIL_OFS = 6'h08;
  localparam logic [5:0] IRQ_STATUS_OFS = 6'h0c;
  localparam logic [5:0] IRQ_MASK_OFS = 6'h10;
  localparam logic [5:0] RTC_OFS = 6'h14;
  localparam logic [5:0] STAMP_OFS = 6'h18;
  localparam logic [5:0] PKT_RATE_OFS = 6'h1c;
  localparam logic [5:0] NEAR_PERF_OFS = 6'h20;
  localparam logic [5:0] FAR_PERF_OFS = 6'h24;
  localparam logic [5:0] SES_THRESH_OFS = 6'h28;
  // control field positions
  localparam int CTRL_PDH_MON = 0;
  localparam int CTRL_MPEG_MON = 1;
  localparam int CTRL_CELL_DISCARD = 2;
  localparam int CTRL_HEC_CORRECT = 3;
  localparam int CTRL_FMT_204 = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h03; // both groups monitored
  // interrupt status bits
  localparam int IRQ_DECLARE = 0;
  localparam int IRQ_CLEAR = 1;
  localparam int IRQ_ES = 2;
  localparam int IRQ_SES = 3;
  localparam int IRQ_PERIOD15 = 4;
  localparam int IRQ_PERIOD24 = 5;
  localparam int IRQ_W = 6;
  localparam logic [15:0] SES_THRESH_RESET = 16'hffff;
  localparam int PATH_ID_W = 12;
endpackage

// ===== design/em_supervision.sv
`timescale 1ns/1ps
// Function
// R1: every reported fault cause, plus a hardware failure input, passes through a persistency filter.
// R2: per-second window data are turned into errored, severely errored and background block events.
// R3: the filter takes the listed causes of the physical, path, cell, adaptation and mpeg functions.
// R4: events and reports are stamped with one-second resolution from the local clock; only failure declare and clear events are stamped here.
// R5: 15 minute and 24 hour periods start in line with the local clock, within 10 seconds.
// R6: settings are written by the manager and each read returns a status report.
// R7: each function takes monitored or not monitored, and both physical interfaces report it.
// R8: the pdh interface, its path termination and its cell monitor share one supervision state.
// R9: the mpeg interface, its adaptation and its path entity share one supervision state.
// R10: cell discard and header correction modes and the path identifier are set and read back.
// R11: the mpeg interface reports how many transport packets it handles per second.
// R12: the mpeg output format selects 188 byte or 204 byte packets with 16 dummy bytes.
// R13: loss of signal reaches management only while its interface is monitored.
// R14: failure declared after 2,5 s of continuous cause and cleared after 10 s of absence.
// R15: causes of a group held not monitored are masked before the filter.
module em_supervision #(
  parameter int unsigned SEC_CYCLES = em_sup_pkg::SEC_CYCLES,
  parameter int unsigned DECLARE_CYCLES = em_sup_pkg::DECLARE_CYCLES,
  parameter int unsigned CLEAR_CYCLES = em_sup_pkg::CLEAR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic pdh_signal_loss,
  input wire logic ais,
  input wire logic frame_loss,
  input wire logic remote_alarm,
  input wire logic remote_error,
  input wire logic remote_defect,
  input wire logic cell_delin_loss,
  input wire logic adapt_status,
  input wire logic sni_fail,
  input wire logic lmc_fail,
  input wire logic mpeg_signal_loss,
  input wire logic in_slip_err,
  input wire logic out_slip_err,
  input wire logic hw_fail,
  input wire logic perf_valid,
  input wire logic near_ds,
  input wire logic [15:0] near_ebc,
  input wire logic far_ds,
  input wire logic [15:0] far_ebc,
  input wire logic ts_packet,
  output logic [13:0] failure,
  output logic sec_pulse,
  output logic pdh_phys_if_mon,
  output logic path_term_mon,
  output logic vp_monitor_mon,
  output logic mpeg_phys_if_mon,
  output logic mpeg_adapt_mon,
  output logic vp_entity_mon,
  output logic cell_discard,
  output logic hec_correct,
  output logic [11:0] path_identifier,
  output logic fmt_204
);
  localparam int N = em_sup_pkg::NUM_CAUSES;

  logic [em_sup_pkg::CTRL_W-1:0] ctrl;
  logic [em_sup_pkg::IRQ_W-1:0] irq_status;
  logic [em_sup_pkg::IRQ_W-1:0] irq_mask;
  logic [em_sup_pkg::IRQ_W-1:0] irq_event;
  logic [15:0] ses_thresh;
  logic [31:0] sec_cnt;
  logic [16:0] rtc;
  logic [16:0] next_rtc;
  logic [16:0] stamp;
  logic [15:0] pkt_cnt;
  logic [15:0] pkt_rate;
  logic [17:0] near_perf;
  logic [17:0] far_perf;
  logic [N-1:0] cause;
  logic [N-1:0] masked;
  logic [N-1:0] declare_ev;
  logic [N-1:0] clear_ev;
  logic [31:0] cnt [N];
  logic wr_ctrl;
  logic wr_rtc;
  logic period15;
  logic period24;
  logic nses;
  logic fses;

  assign wr_ctrl = reg_wr && (reg_addr == em_sup_pkg::CTRL_OFS);
  assign wr_rtc = reg_wr && (reg_addr == em_sup_pkg::RTC_OFS);

  // configuration written by the manager
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= em_sup_pkg::CTRL_RESET;
      path_identifier <= '0;
      ses_thresh <= em_sup_pkg::SES_THRESH_RESET;
      irq_mask <= '0;
    end else if (reg_wr) begin
      case (reg_addr) // R6
        em_sup_pkg::CTRL_OFS: ctrl <= reg_wdata[em_sup_pkg::CTRL_W-1:0];
        em_sup_pkg::PATH_ID_OFS: path_identifier <= reg_wdata[em_sup_pkg::PATH_ID_W-1:0]; // R10
        em_sup_pkg::SES_THRESH_OFS: ses_thresh <= reg_wdata[15:0];
        em_sup_pkg::IRQ_MASK_OFS: irq_mask <= reg_wdata[em_sup_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // one control bit per group keeps every member of the group in step
  assign pdh_phys_if_mon = ctrl[em_sup_pkg::CTRL_PDH_MON]; // R7 R8
  assign path_term_mon = ctrl[em_sup_pkg::CTRL_PDH_MON]; // R8
  assign vp_monitor_mon = ctrl[em_sup_pkg::CTRL_PDH_MON]; // R8
  assign mpeg_phys_if_mon = ctrl[em_sup_pkg::CTRL_MPEG_MON]; // R7 R9
  assign mpeg_adapt_mon = ctrl[em_sup_pkg::CTRL_MPEG_MON]; // R9
  assign vp_entity_mon = ctrl[em_sup_pkg::CTRL_MPEG_MON]; // R9
  assign cell_discard = ctrl[em_sup_pkg::CTRL_CELL_DISCARD]; // R10
  assign hec_correct = ctrl[em_sup_pkg::CTRL_HEC_CORRECT]; // R10
  assign fmt_204 = ctrl[em_sup_pkg::CTRL_FMT_204]; // R12

  // one-second tick from the system clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt <= '0;
      sec_pulse <= 1'b0;
    end else if (sec_cnt == SEC_CYCLES - 1) begin
      sec_cnt <= '0;
      sec_pulse <= 1'b1;
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
      sec_pulse <= 1'b0;
    end
  end

  // local clock as seconds of day; a write realigns it to network time
  always_comb begin
    next_rtc = rtc + 17'h1;
    if (next_rtc == em_sup_pkg::DAY_SECONDS) begin
      next_rtc = '0;
    end
  end

  // periods begin exactly on clock boundaries, well inside the 10 s allowance
  assign period15 = sec_pulse && !wr_rtc && (next_rtc % em_sup_pkg::QUARTER_SECONDS == 17'h0); // R5
  assign period24 = sec_pulse && !wr_rtc && (next_rtc == 17'h0); // R5

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rtc <= '0;
    end else if (wr_rtc) begin
      rtc <= reg_wdata[16:0];
    end else if (sec_pulse) begin
      rtc <= next_rtc; // R4
    end
  end

  // cause vector in fixed order; hardware failure joins the same filter
  assign cause = {hw_fail, out_slip_err, in_slip_err, mpeg_signal_loss, lmc_fail, sni_fail,
                  adapt_status, cell_delin_loss, remote_defect, remote_error, remote_alarm,
                  frame_loss, ais, pdh_signal_loss}; // R1 R3

  // persistency filter, one counter per cause
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_filter
      if (gi <= em_sup_pkg::PDH_LAST) begin : g_pdh
        assign masked[gi] = cause[gi] && ctrl[em_sup_pkg::CTRL_PDH_MON]; // R13 R15
      end else if (gi <= em_sup_pkg::MPEG_LAST) begin : g_mpeg
        assign masked[gi] = cause[gi] && ctrl[em_sup_pkg::CTRL_MPEG_MON]; // R13 R15
      end else begin : g_hw
        assign masked[gi] = cause[gi];
      end
      // counter restarts whenever the cause agrees with the filtered state
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt[gi] <= '0;
          failure[gi] <= 1'b0;
        end else if (masked[gi] == failure[gi]) begin
          cnt[gi] <= '0;
        end else if (!failure[gi] && cnt[gi] == DECLARE_CYCLES - 1) begin
          cnt[gi] <= '0;
          failure[gi] <= 1'b1; // R14
        end else if (failure[gi] && cnt[gi] == CLEAR_CYCLES - 1) begin
          cnt[gi] <= '0;
          failure[gi] <= 1'b0; // R14
        end else begin
          cnt[gi] <= cnt[gi] + 32'h1;
        end
      end
      assign declare_ev[gi] = !failure[gi] && masked[gi] && cnt[gi] == DECLARE_CYCLES - 1;
      assign clear_ev[gi] = failure[gi] && !masked[gi] && cnt[gi] == CLEAR_CYCLES - 1;
    end
  endgenerate

  // time of the last failure change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stamp <= '0;
    end else if (|declare_ev || |clear_ev) begin
      stamp <= rtc; // R4
    end
  end

  // per-second events; near defect seconds suppress far events
  assign nses = near_ds || near_ebc >= ses_thresh;
  assign fses = !near_ds && (far_ds || far_ebc >= ses_thresh);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      near_perf <= '0;
      far_perf <= '0;
    end else if (perf_valid) begin
      near_perf <= {nses, near_ds || near_ebc != 16'h0, nses ? 16'h0 : near_ebc}; // R2
      far_perf <= {fses, !near_ds && (far_ds || far_ebc != 16'h0),
                   (fses || near_ds) ? 16'h0 : far_ebc}; // R2
    end
  end

  // packets counted over each second and reported as the rate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_cnt <= '0;
      pkt_rate <= '0;
    end else if (sec_pulse) begin
      pkt_cnt <= {15'h0, ts_packet};
      pkt_rate <= pkt_cnt; // R11
    end else if (ts_packet && pkt_cnt != 16'hffff) begin
      pkt_cnt <= pkt_cnt + 16'h1; // saturates rather than wrapping to a small rate
    end
  end

  // sticky events; a new event wins over a write-one clear in the same cycle
  assign irq_event = {period24, period15, perf_valid && nses,
                      perf_valid && (near_ds || near_ebc != 16'h0), |clear_ev, |declare_ev};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (reg_wr && reg_addr == em_sup_pkg::IRQ_STATUS_OFS) begin
      irq_status <= (irq_status & ~reg_wdata[em_sup_pkg::IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // status reports; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr) // R6
        em_sup_pkg::CTRL_OFS: reg_rdata <= {27'h0, ctrl}; // R7 R10 R12
        em_sup_pkg::PATH_ID_OFS: reg_rdata <= {20'h0, path_identifier}; // R10
        em_sup_pkg::FAIL_OFS: reg_rdata <= {18'h0, failure};
        em_sup_pkg::IRQ_STATUS_OFS: reg_rdata <= {26'h0, irq_status};
        em_sup_pkg::IRQ_MASK_OFS: reg_rdata <= {26'h0, irq_mask};
        em_sup_pkg::RTC_OFS: reg_rdata <= {15'h0, rtc};
        em_sup_pkg::STAMP_OFS: reg_rdata <= {15'h0, stamp};
        em_sup_pkg::PKT_RATE_OFS: reg_rdata <= {16'h0, pkt_rate}; // R11
        em_sup_pkg::NEAR_PERF_OFS: reg_rdata <= {14'h0, near_perf};
        em_sup_pkg::FAR_PERF_OFS: reg_rdata <= {14'h0, far_perf};
        em_sup_pkg::SES_THRESH_OFS: reg_rdata <= {16'h0, ses_thresh};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  property p_filter_masks_pdh;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(failure[0]) |-> $past(ctrl[em_sup_pkg::CTRL_PDH_MON]) && $past(pdh_signal_loss);
  endproperty
  a_filter_masks_pdh: assert property (p_filter_masks_pdh) // R15
    else $error("pdh loss declared while not monitored");

  property p_mpeg_mask;
    @(posedge ref_clk) disable iff (!rst_n)
    !ctrl[em_sup_pkg::CTRL_MPEG_MON] && !failure[10] |=> !failure[10];
  endproperty
  a_mpeg_mask: assert property (p_mpeg_mask) // R13
    else $error("mpeg loss raised while not monitored");

  property p_declare_time;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(failure[13]) |-> $past(cnt[13]) == DECLARE_CYCLES - 1 && $past(hw_fail);
  endproperty
  a_declare_time: assert property (p_declare_time) // R14
    else $error("failure declared at wrong persistency count");

  property p_clear_time;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(failure[13]) |-> $past(cnt[13]) == CLEAR_CYCLES - 1 && !$past(hw_fail);
  endproperty
  a_clear_time: assert property (p_clear_time) // R14
    else $error("failure cleared at wrong absence count");

  property p_rtc_tick;
    @(posedge ref_clk) disable iff (!rst_n)
    sec_pulse && !wr_rtc && rtc != em_sup_pkg::DAY_SECONDS - 1 |=> rtc == $past(rtc) + 17'h1;
  endproperty
  a_rtc_tick: assert property (p_rtc_tick) // R4
    else $error("local clock did not advance on the second");

  property p_period;
    @(posedge ref_clk) disable iff (!rst_n)
    period24 |-> period15 ##1 rtc == 17'h0;
  endproperty
  a_period: assert property (p_period) // R5
    else $error("day period not aligned to clock");

  property p_near_ses;
    @(posedge ref_clk) disable iff (!rst_n)
    perf_valid && near_ds |=> near_perf[17:16] == 2'h3 && near_perf[15:0] == 16'h0;
  endproperty
  a_near_ses: assert property (p_near_ses) // R2
    else $error("defect second not severely errored");

  property p_read_ctrl;
    @(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == em_sup_pkg::CTRL_OFS |=> reg_rdata[4:0] == $past(ctrl);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) // R6
    else $error("control read back wrong");

  property p_groups;
    @(posedge ref_clk) disable iff (!rst_n)
    pdh_phys_if_mon == path_term_mon && path_term_mon == vp_monitor_mon
      && mpeg_phys_if_mon == mpeg_adapt_mon && mpeg_adapt_mon == vp_entity_mon;
  endproperty
  a_groups: assert property (p_groups) // R8
    else $error("group members in different supervision states");

  property p_pkt_rate;
    @(posedge ref_clk) disable iff (!rst_n)
    sec_pulse |=> pkt_rate == $past(pkt_cnt);
  endproperty
  a_pkt_rate: assert property (p_pkt_rate) // R11
    else $error("packet rate not latched on the second");

  property p_fmt;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_ctrl |=> fmt_204 == $past(reg_wdata[em_sup_pkg::CTRL_FMT_204]);
  endproperty
  a_fmt: assert property (p_fmt) // R12
    else $error("format setting not applied");
endmodule

// ===== bench/basic_fn_model.sv
`timescale 1ns/1ps
// transport stream source: a fixed number of packets in each second
module basic_fn_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sec_pulse,
  input wire logic [7:0] pkts_per_sec,
  output logic ts_packet
);
  logic [7:0] left;

  // pulses every other cycle so that no two packets merge into one level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 8'h00;
      ts_packet <= 1'b0;
    end else if (sec_pulse) begin
      left <= pkts_per_sec;
      ts_packet <= 1'b0;
    end else begin
      ts_packet <= (left != 8'h00) && !ts_packet;
      if ((left != 8'h00) && !ts_packet) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule

// ===== bench/equipment_mgmt_supervision_tb_top.sv
`timescale 1ns/1ps
module equipment_mgmt_supervision_tb_top;
  // short counts keep the run brief; expectations derive from these
  localparam int unsigned SEC = 20;
  localparam int unsigned DECL = 5;
  localparam int unsigned CLR = 12;
  logic ref_clk;
  logic rst_n;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic irq;
  logic [13:0] causes;
  logic perf_valid, near_ds, far_ds;
  logic [15:0] near_ebc, far_ebc;
  logic ts_packet;
  logic [13:0] failure;
  logic sec_pulse;
  logic [5:0] mon;
  logic cell_discard, hec_correct, fmt_204;
  logic [11:0] path_identifier;
  logic [7:0] pkts_per_sec;
  logic [31:0] d;
  int errors;
  int tests_run;

  em_supervision #(.SEC_CYCLES(SEC), .DECLARE_CYCLES(DECL), .CLEAR_CYCLES(CLR)) u_em_supervision (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .pdh_signal_loss(causes[0]), .ais(causes[1]), .frame_loss(causes[2]),
    .remote_alarm(causes[3]), .remote_error(causes[4]), .remote_defect(causes[5]),
    .cell_delin_loss(causes[6]), .adapt_status(causes[7]), .sni_fail(causes[8]),
    .lmc_fail(causes[9]), .mpeg_signal_loss(causes[10]), .in_slip_err(causes[11]),
    .out_slip_err(causes[12]), .hw_fail(causes[13]), .perf_valid(perf_valid),
    .near_ds(near_ds), .near_ebc(near_ebc), .far_ds(far_ds), .far_ebc(far_ebc),
    .ts_packet(ts_packet), .failure(failure), .sec_pulse(sec_pulse),
    .pdh_phys_if_mon(mon[0]), .path_term_mon(mon[1]), .vp_monitor_mon(mon[2]),
    .mpeg_phys_if_mon(mon[3]), .mpeg_adapt_mon(mon[4]), .vp_entity_mon(mon[5]),
    .cell_discard(cell_discard), .hec_correct(hec_correct),
    .path_identifier(path_identifier), .fmt_204(fmt_204)
  );

  basic_fn_model u_basic_fn_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .sec_pulse(sec_pulse),
    .pkts_per_sec(pkts_per_sec), .ts_packet(ts_packet)
  );

  // free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample it there
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic wait_sec;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (sec_pulse !== 1'b1 && n < 100);
    chk({31'h0, sec_pulse}, 32'h1);
  endtask

  task automatic test_reset;
    chk({26'h0, mon}, 32'h3f);
    rdchk(em_sup_pkg::CTRL_OFS, 32'h03);
    rdchk(em_sup_pkg::SES_THRESH_OFS, 32'hffff);
    rdchk(6'h3c, 32'h0);
  endtask

  task automatic test_config;
    wr(em_sup_pkg::CTRL_OFS, 32'h1c);
    @(posedge ref_clk);
    #1;
    chk({26'h0, mon}, 32'h00);
    chk({29'h0, cell_discard, hec_correct, fmt_204}, 32'h7);
    rdchk(em_sup_pkg::CTRL_OFS, 32'h1c);
    wr(em_sup_pkg::CTRL_OFS, 32'h05);
    @(posedge ref_clk);
    #1;
    chk({26'h0, mon}, 32'h07);
    chk({29'h0, cell_discard, hec_correct, fmt_204}, 32'h4);
    wr(em_sup_pkg::PATH_ID_OFS, 32'habc);
    rdchk(em_sup_pkg::PATH_ID_OFS, 32'habc);
    chk({20'h0, path_identifier}, 32'habc);
    wr(em_sup_pkg::FAIL_OFS, 32'hffffffff);
    rdchk(em_sup_pkg::FAIL_OFS, 32'h0);
  endtask

  // one cause held through declaration, then removed through clearing
  task automatic filt(input int idx, input logic [31:0] ctrl, input logic exp);
    logic [31:0] f;
    f = exp ? (32'h1 << idx) : 32'h0;
    wr(em_sup_pkg::CTRL_OFS, ctrl);
    @(posedge ref_clk);
    causes[idx] <= 1'b1;
    repeat (DECL - 1) @(posedge ref_clk);
    #1;
    chk({18'h0, failure}, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({18'h0, failure}, f);
    rdchk(em_sup_pkg::FAIL_OFS, f);
    @(posedge ref_clk);
    causes[idx] <= 1'b0;
    repeat (CLR - 1) @(posedge ref_clk);
    #1;
    chk({18'h0, failure}, f);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({18'h0, failure}, 32'h0);
  endtask

  task automatic test_filter;
    for (int i = 0; i < 14; i++) begin
      filt(i, 32'h03, 1'b1);
    end
    filt(0, 32'h02, 1'b0);
    filt(10, 32'h01, 1'b0);
    // pin the clock phase: the clear lands after the next tick, so it stamps start plus one
    wait_sec();
    wr(em_sup_pkg::RTC_OFS, 32'h123);
    filt(13, 32'h00, 1'b1);
    rdchk(em_sup_pkg::STAMP_OFS, 32'h124);
  endtask

  task automatic perf(input logic nd, input logic [15:0] ne, input logic fd,
                      input logic [15:0] fe, input logic [31:0] en, input logic [31:0] ef);
    @(posedge ref_clk);
    perf_valid <= 1'b1;
    near_ds <= nd;
    near_ebc <= ne;
    far_ds <= fd;
    far_ebc <= fe;
    @(posedge ref_clk);
    perf_valid <= 1'b0;
    rdchk(em_sup_pkg::NEAR_PERF_OFS, en);
    rdchk(em_sup_pkg::FAR_PERF_OFS, ef);
  endtask

  task automatic test_perf;
    wr(em_sup_pkg::SES_THRESH_OFS, 32'h0a);
    perf(1'b0, 16'h5, 1'b1, 16'h0, 32'h10005, 32'h30000);
    perf(1'b0, 16'ha, 1'b0, 16'h3, 32'h30000, 32'h10003);
    perf(1'b1, 16'h0, 1'b1, 16'h7, 32'h30000, 32'h0);
    // declare, clear, errored and severely errored events are all sticky by now
    rdchk(em_sup_pkg::IRQ_STATUS_OFS, 32'h0f);
  endtask

  task automatic test_pkt_rate;
    wait_sec();
    wait_sec();
    rdchk(em_sup_pkg::PKT_RATE_OFS, 32'h3);
  endtask

  // clock rollover into a period start raises its status bit and the irq
  task automatic rtc_roll(input logic [31:0] start, input logic [31:0] exp, input int b);
    wr(em_sup_pkg::IRQ_STATUS_OFS, 32'h3f);
    wr(em_sup_pkg::IRQ_MASK_OFS, 32'h1 << b);
    wait_sec();
    wr(em_sup_pkg::RTC_OFS, start);
    wait_sec();
    rdchk(em_sup_pkg::RTC_OFS, exp);
    chk({31'h0, irq}, 32'h1);
    wr(em_sup_pkg::IRQ_STATUS_OFS, 32'h1 << b);
    @(posedge ref_clk);
    #1;
    chk({31'h0, irq}, 32'h0);
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    causes = 14'h0;
    perf_valid = 1'b0;
    near_ds = 1'b0;
    near_ebc = 16'h0;
    far_ds = 1'b0;
    far_ebc = 16'h0;
    pkts_per_sec = 8'h03;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_config();
    test_filter();
    test_perf();
    test_pkt_rate();
    rtc_roll(32'h383, 32'h384, em_sup_pkg::IRQ_PERIOD15);
    rtc_roll(32'h1517f, 32'h0, em_sup_pkg::IRQ_PERIOD24);
    print_verdict();
  end

  // the whole run needs well under a tenth of this span
  initial begin
    #400000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
